// ===== logic/sector_write_command.sv
// Sector write command interpreter: APB task-file slave that takes the
// write opcode, collects 16-bit data words and commits sectors to media.
// Assumes the media port is on i_clock and answers each commit with one
// i_media_done pulse.
// Only the 8-bit-count write is decoded; any other opcode is aborted.
// Task-file writes while busy or requesting data are dropped, not queued.
//
// Contract
// R1: Host supplies sectors; device records them onto the media.
// R2: Payload moves as 16-bit words through the data register.
// R3: Without auto reassign, unrecoverable error stops write at failing sector.
// R4: Sector count gives sectors to write; zero means 256.
// R5: Address-low is sector number, or address bits 0-7 in logical mode.
// R6: Address-mid/high are cylinder, or address bits 8-15 and 16-23.
// R7: Device register low nibble is head, or address bits 24-27.
// R8: Opcodes 30h and 31h are the same command; retry bit ignored.
// R9: At end, count holds requested sectors not transferred.
// R10: At end, address registers hold the last transferred sector.
// R11: At end, busy clears; ready, fault, seek, error bits reported.
// R12: Host loads registers before opcode and moves data only on request.
module sector_write_command (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Media word stream
  output logic             o_word_valid,
  output logic [15:0]      o_word_data,
  // Media sector commit
  output logic             o_commit,
  output logic [27:0]      o_commit_addr,
  output logic             o_commit_lba,
  input  wire logic        i_media_done,
  input  wire logic        i_media_unrecoverable,
  input  wire logic        i_media_fault
);

  // Registered state and next values
  sector_write_pkg::taskfile_s tf_q, tf_d;
  sector_write_pkg::state_e    st_q, st_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  err_q, err_d;
  logic        df_q, df_d;
  logic [8:0]  left_q, left_d;
  logic [7:0]  word_q, word_d;
  logic [31:0] prdata_q, prdata_d;
  logic        wvalid_q, wvalid_d;
  logic [15:0] wdata_q, wdata_d;
  logic        commit_q, commit_d;

  // Decodes and status
  logic        access;
  logic        wr_acc;
  logic        mapped;
  logic        drq;
  logic        bsy;
  logic        lba_mode;
  logic        reassign;
  logic        media_stop;
  logic [7:0]  status;
  logic [27:0] cur_addr;
  logic [27:0] next_addr;
  logic        opcode_hit;
  logic        unrec_stop;

  // Bus decode
  assign access   = i_psel & i_penable;
  assign wr_acc   = access & i_pwrite;
  assign lba_mode = tf_q.dev[sector_write_pkg::DEV_LBA_BIT];
  assign reassign = ctrl_q[sector_write_pkg::CTRL_REASSIGN_BIT];
  assign drq      = (st_q == sector_write_pkg::ST_XFER);
  assign bsy      = (st_q == sector_write_pkg::ST_COMMIT);

  // Map of known offsets
  // Misaligned and out-of-range offsets fall to the error answer
  always_comb begin
    case (i_paddr)
      sector_write_pkg::OFF_DATA,
      sector_write_pkg::OFF_ERROR,
      sector_write_pkg::OFF_COUNT,
      sector_write_pkg::OFF_ADDR_LO,
      sector_write_pkg::OFF_ADDR_MI,
      sector_write_pkg::OFF_ADDR_HI,
      sector_write_pkg::OFF_DEVICE,
      sector_write_pkg::OFF_COMMAND,
      sector_write_pkg::OFF_CONTROL: mapped = 1'b1;
      default:                       mapped = 1'b0;
    endcase
  end

  // R11 status byte
  // Ready stands high; busy only while committing, and seek complete low only then
  assign status = {bsy, 1'b1, df_q, ~bsy, drq, 1'b0, 1'b0, |err_q};

  // R5 R6 R7 working address from task file
  assign cur_addr = {tf_q.dev[3:0], tf_q.hi, tf_q.mi, tf_q.lo};

  // Next sector address in the current mode
  // Geometry rolls sector, then head, then cylinder
  address_stepper u_stepper (
    .i_lba_mode (lba_mode),
    .i_addr     (cur_addr),
    .o_next     (next_addr)
  );

  // R3 unrecoverable error ends the write only with auto reassign off;
  // with it on the sector is remapped and the write goes on
  assign unrec_stop = i_media_unrecoverable & ~reassign;
  assign media_stop = i_media_fault | unrec_stop;

  // R8 opcode match with the retry flag masked off
  assign opcode_hit = (i_pwdata[7:0] & sector_write_pkg::OP_RETRY_MASK) ==
                      sector_write_pkg::OP_WRITE_SECTORS;

  // Read data captured in the setup cycle
  // so it already stands in the zero-wait access phase;
  // data register reads return zero, the word path is write only
  always_comb begin
    prdata_d = prdata_q;
    if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        sector_write_pkg::OFF_ERROR:   prdata_d = {24'h000000, err_q};
        sector_write_pkg::OFF_COUNT:   prdata_d = {24'h000000, tf_q.count};
        sector_write_pkg::OFF_ADDR_LO: prdata_d = {24'h000000, tf_q.lo};
        sector_write_pkg::OFF_ADDR_MI: prdata_d = {24'h000000, tf_q.mi};
        sector_write_pkg::OFF_ADDR_HI: prdata_d = {24'h000000, tf_q.hi};
        sector_write_pkg::OFF_DEVICE:  prdata_d = {24'h000000, tf_q.dev};
        sector_write_pkg::OFF_COMMAND: prdata_d = {24'h000000, status};
        sector_write_pkg::OFF_CONTROL: prdata_d = {24'h000000, ctrl_q};
        default:                       prdata_d = 32'h00000000;
      endcase
    end
  end

  // Command sequencing, next values
  // Pulses default low; word data holds until the next word
  always_comb begin
    tf_d     = tf_q;
    st_d     = st_q;
    ctrl_d   = ctrl_q;
    err_d    = err_q;
    df_d     = df_q;
    left_d   = left_q;
    word_d   = word_q;
    wvalid_d = 1'b0;
    wdata_d  = wdata_q;
    commit_d = 1'b0;
    case (st_q)
      sector_write_pkg::ST_IDLE: begin
        // Task file and control writable only while idle
        if (wr_acc && mapped) begin
          case (i_paddr)
            sector_write_pkg::OFF_COUNT:   tf_d.count = i_pwdata[7:0];
            sector_write_pkg::OFF_ADDR_LO: tf_d.lo    = i_pwdata[7:0];
            sector_write_pkg::OFF_ADDR_MI: tf_d.mi    = i_pwdata[7:0];
            sector_write_pkg::OFF_ADDR_HI: tf_d.hi    = i_pwdata[7:0];
            sector_write_pkg::OFF_DEVICE:  tf_d.dev   = i_pwdata[7:0];
            sector_write_pkg::OFF_CONTROL: ctrl_d     = i_pwdata[7:0];
            sector_write_pkg::OFF_COMMAND: begin
              err_d = 8'h00;
              df_d  = 1'b0;
              // R8 either opcode starts the write
              if (opcode_hit) begin
                // R4 zero count means 256
                left_d = (tf_q.count == 8'h00) ? sector_write_pkg::ZERO_COUNT_SECT
                                               : {1'b0, tf_q.count};
                word_d = 8'h00;
                st_d   = sector_write_pkg::ST_XFER;
              end else begin
                // R11 unknown opcode aborted
                err_d[sector_write_pkg::ERR_ABT_BIT] = 1'b1;
              end
            end
            default: ;
          endcase
        end
      end
      sector_write_pkg::ST_XFER: begin
        // R2 one 16-bit word per data write
        // R12 data taken only while requested
        if (wr_acc && i_paddr == sector_write_pkg::OFF_DATA) begin
          wvalid_d = 1'b1;
          wdata_d  = i_pwdata[15:0];
          // Wraps to zero after the last word of a sector
          word_d   = word_q + 8'h01;
          if (word_q == sector_write_pkg::LAST_WORD_IDX) begin
            // R1 sector complete, record it
            commit_d = 1'b1;
            st_d     = sector_write_pkg::ST_COMMIT;
          end
        end
      end
      sector_write_pkg::ST_COMMIT: begin
        // Busy until the media answers for this sector
        if (i_media_done) begin
          if (media_stop) begin
            // R3 stop at failing sector
            if (i_media_fault) begin
              df_d = 1'b1;
              err_d[sector_write_pkg::ERR_ABT_BIT] = 1'b1;
            end
            if (unrec_stop) begin
              err_d[sector_write_pkg::ERR_IDN_BIT] = 1'b1;
            end
            // R9 sectors not transferred
            // A full 256 left reads back as zero, as a zero count does
            tf_d.count = left_q[7:0];
            st_d       = sector_write_pkg::ST_IDLE;
          end else if (left_q == 9'h001) begin
            // R9 R10 all done, address stays on last sector
            left_d     = 9'h000;
            tf_d.count = 8'h00;
            st_d       = sector_write_pkg::ST_IDLE;
          end else begin
            // R10 advance to next sector
            // Address registers step only once the media took the sector
            left_d     = left_q - 9'h001;
            tf_d.lo    = next_addr[7:0];
            tf_d.mi    = next_addr[15:8];
            tf_d.hi    = next_addr[23:16];
            tf_d.dev   = {tf_q.dev[7:4], next_addr[27:24]};
            word_d     = 8'h00;
            st_d       = sector_write_pkg::ST_XFER;
          end
        end
      end
      // Unused code returns to idle
      default: st_d = sector_write_pkg::ST_IDLE;
    endcase
  end

  // Command state registers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      tf_q.count <= sector_write_pkg::COUNT_RESET;
      tf_q.dev   <= sector_write_pkg::DEVICE_RESET;
      tf_q.hi    <= 8'h00;
      tf_q.mi    <= 8'h00;
      tf_q.lo    <= sector_write_pkg::ADDR_LO_RESET;
      st_q       <= sector_write_pkg::ST_IDLE;
      ctrl_q     <= sector_write_pkg::CONTROL_RESET;
      err_q      <= 8'h00;
      df_q       <= 1'b0;
      left_q     <= 9'h000;
      word_q     <= 8'h00;
    end else begin
      tf_q       <= tf_d;
      st_q       <= st_d;
      ctrl_q     <= ctrl_d;
      err_q      <= err_d;
      df_q       <= df_d;
      left_q     <= left_d;
      word_q     <= word_d;
    end
  end

  // Read data register
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prdata_q <= 32'h00000000;
    end else begin
      prdata_q <= prdata_d;
    end
  end

  // Media stream registers, one-cycle pulses
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wvalid_q <= 1'b0;
      wdata_q  <= 16'h0000;
      commit_q <= 1'b0;
    end else begin
      wvalid_q <= wvalid_d;
      wdata_q  <= wdata_d;
      commit_q <= commit_d;
    end
  end

  // Bus answers: no wait states
  assign o_pready  = access;

  // Unmapped offsets answer with an error and change nothing
  assign o_pslverr = access & ~mapped;

  // Read data from its register
  assign o_prdata  = prdata_q;

  // Media word stream
  assign o_word_valid  = wvalid_q;
  assign o_word_data   = wdata_q;

  // Commit address comes straight from the task file, which steps only
  // on the done pulse, so it holds for the whole commit
  assign o_commit      = commit_q;
  assign o_commit_addr = cur_addr;
  assign o_commit_lba  = lba_mode;

endmodule // sector_write_command

// ===== logic/sector_write_pkg.sv
// Package: task-file map, field positions, opcodes and states for the
// sector write command interpreter.
// Assumes an APB master with 32-bit data; one register per aligned word.
package sector_write_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] OFF_DATA    = 8'h00;  // Sector data, 16-bit words
  localparam logic [7:0] OFF_ERROR   = 8'h04;  // command_error_report / feature
  localparam logic [7:0] OFF_COUNT   = 8'h08;  // Sector count
  localparam logic [7:0] OFF_ADDR_LO = 8'h0C;  // Sector number / address bits 7:0
  localparam logic [7:0] OFF_ADDR_MI = 8'h10;  // Cylinder low / address bits 15:8
  localparam logic [7:0] OFF_ADDR_HI = 8'h14;  // Cylinder high / address bits 23:16
  localparam logic [7:0] OFF_DEVICE  = 8'h18;  // Mode bit and head / address bits 27:24
  localparam logic [7:0] OFF_COMMAND = 8'h1C;  // Opcode on write, device_state_report on read
  localparam logic [7:0] OFF_CONTROL = 8'h20;  // Auto reassign enable

  // Opcode match: bit 0 is the ignored retry flag
  localparam logic [7:0] OP_WRITE_SECTORS = 8'h30;
  localparam logic [7:0] OP_RETRY_MASK    = 8'hFE;

  // Field positions
  localparam int DEV_LBA_BIT      = 6;
  localparam int CTRL_REASSIGN_BIT = 0;
  localparam int ERR_IDN_BIT      = 4;
  localparam int ERR_ABT_BIT      = 2;

  // Reset values
  localparam logic [7:0] DEVICE_RESET  = 8'hA0;
  localparam logic [7:0] COUNT_RESET   = 8'h01;
  localparam logic [7:0] ADDR_LO_RESET = 8'h01;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Transfer sizing
  localparam logic [7:0] LAST_WORD_IDX   = 8'hFF;   // 256 words per sector
  localparam logic [8:0] ZERO_COUNT_SECT = 9'h100;  // Count zero means 256

  // Drive geometry for stepping through sectors in geometry mode
  localparam logic [7:0] SECTORS_PER_TRACK = 8'h3F;
  localparam logic [3:0] LAST_HEAD         = 4'hF;

  // Command-block register set
  typedef struct packed {
    logic [7:0] count;
    logic [7:0] dev;
    logic [7:0] hi;
    logic [7:0] mi;
    logic [7:0] lo;
  } taskfile_s;

  // Interpreter states, Gray along the usual path except COMMIT back to IDLE
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_XFER   = 2'b01,
    ST_COMMIT = 2'b11
  } state_e;

endpackage

// ===== logic/address_stepper.sv
// Address stepper: next sector address in either addressing mode.
// Assumes geometry addresses have sector numbers starting at one.
module address_stepper (
  // Mode and current address
  input  wire logic        i_lba_mode,
  input  wire logic [27:0] i_addr,
  // Next address
  output logic [27:0]      o_next
);

  logic [7:0]  sec;
  logic [15:0] cyl;
  logic [3:0]  head;

  // Split into head, cylinder, sector
  assign sec  = i_addr[7:0];
  assign cyl  = i_addr[23:8];
  assign head = i_addr[27:24];

  // Increment flat address or roll sector, head, cylinder
  always_comb begin
    if (i_lba_mode) begin
      o_next = i_addr + 28'h0000001;
    end else if (sec != sector_write_pkg::SECTORS_PER_TRACK) begin
      o_next = {head, cyl, sec + 8'h01};
    end else if (head != sector_write_pkg::LAST_HEAD) begin
      o_next = {head + 4'h1, cyl, 8'h01};
    end else begin
      o_next = {4'h0, cyl + 16'h0001, 8'h01};
    end
  end

endmodule // address_stepper

// ===== sim/sector_write_command_props.sv
// Checker: port properties of the sector write interpreter.
// Assumes one clock and a synchronous active-high reset.
module sector_write_command_props (
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_word_valid,
  input wire logic [15:0] o_word_data,
  input wire logic        o_commit,
  input wire logic [27:0] o_commit_addr,
  input wire logic        o_commit_lba
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Access phase and data-register write
  logic acc;
  logic dwr;
  assign acc = i_psel & i_penable;
  assign dwr = acc & i_pwrite & (i_paddr == sector_write_pkg::OFF_DATA);

  a_ready_access: assert property (acc |-> o_pready) else $error("no ready");
  a_ready_idle: assert property (!acc |-> !o_pready) else $error("stray ready");
  a_err_unmapped: assert property (acc && i_paddr > 8'h20 |-> o_pslverr)
    else $error("no slverr");
  a_err_mapped: assert property (acc && i_paddr <= 8'h20 && i_paddr[1:0] == 2'b00
    |-> !o_pslverr) else $error("bad slverr");
  a_word_cause: assert property (o_word_valid |-> $past(dwr)) else $error("stray word");
  a_word_value: assert property (o_word_valid |-> o_word_data == $past(i_pwdata[15:0]))
    else $error("word value");
  a_commit_cause: assert property (o_commit |-> $past(dwr)) else $error("stray commit");
  a_commit_pulse: assert property (o_commit |=> !o_commit [*8]) else $error("commit");
  a_addr_hold: assert property (o_commit |=> $stable(o_commit_addr) && $stable(o_commit_lba))
    else $error("addr moved");
  c_commit: cover property (o_commit);
  c_slverr: cover property (o_pslverr);
  c_word: cover property (o_word_valid && o_commit);
endmodule // sector_write_command_props

// ===== sim/media_model.sv
// Media model: answers each sector commit with one done pulse.
// Assumes commit pulses arrive on the same clock.
module media_model (
  input  wire logic i_clock,
  input  wire logic i_rst,
  input  wire logic i_commit,
  input  wire logic i_bad,
  input  wire logic i_slow,
  input  wire logic i_fault,
  output logic      o_done,
  output logic      o_unrec,
  output logic      o_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  int wait_q;
  // record sector, answer prompt or slow
  always_ff @(posedge i_clock) begin
    o_done <= 1'b0;
    if (i_rst) wait_q <= 0;
    else if (i_commit) wait_q <= i_slow ? 20 : 1;
    else if (wait_q == 1) begin
      o_done <= 1'b1;
      wait_q <= 0;
    end else if (wait_q > 1) wait_q <= wait_q - 1;
  end
  // failure flag valid only with done
  assign o_unrec = o_done ? i_bad : ~i_bad;
  assign o_fault = o_done ? i_fault : ~i_fault;
endmodule // media_model

// ===== sim/test_sector_write_command.sv
// Testbench: APB host driving write commands against the media model.
// Assumes the interpreter answers APB with no wait states.
module test_sector_write_command;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clock = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic [31:0] o_prdata;
  logic        o_pready, o_pslverr, o_word_valid, o_commit, o_commit_lba, seen_lba;
  logic [15:0] o_word_data;
  logic [27:0] o_commit_addr, seen_addr;
  logic        i_media_done, i_media_unrecoverable, i_media_fault, serr;
  logic        bad = 1'b0;
  logic        slow = 1'b0;
  logic        fault = 1'b0;
  int          err_total = 0;
  int          n_compared = 0;
  int          cyc = 0;

  always #2.5 i_clock = ~i_clock;
  sector_write_command u_dut (
    .i_clock               (i_clock),
    .i_rst                 (i_rst),
    .i_psel                (i_psel),
    .i_penable             (i_penable),
    .i_pwrite              (i_pwrite),
    .i_paddr               (i_paddr),
    .i_pwdata              (i_pwdata),
    .o_prdata              (o_prdata),
    .o_pready              (o_pready),
    .o_pslverr             (o_pslverr),
    .o_word_valid          (o_word_valid),
    .o_word_data           (o_word_data),
    .o_commit              (o_commit),
    .o_commit_addr         (o_commit_addr),
    .o_commit_lba          (o_commit_lba),
    .i_media_done          (i_media_done),
    .i_media_unrecoverable (i_media_unrecoverable),
    .i_media_fault         (i_media_fault)
  );
  media_model u_media (.i_clock(i_clock), .i_rst(i_rst), .i_commit(o_commit), .i_bad(bad),
    .i_slow(slow), .i_fault(fault), .o_done(i_media_done), .o_unrec(i_media_unrecoverable),
    .o_fault(i_media_fault));
  // Last committed address and mode
  always @(posedge i_clock) if (o_commit) begin
    seen_addr <= o_commit_addr;
    seen_lba <= o_commit_lba;
  end
  // Hang guard
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      conclude();
    end
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    r = o_prdata;
    serr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(n, r, e);
  endtask
  // Poll one status bit until it reads v
  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    do apb(1'b0, sector_write_pkg::OFF_COMMAND, 32'h0, r); while (r[b] !== v);
  endtask
  // task file first, data on request
  task automatic cmd(input logic [7:0] cnt, lo, dv, op, input int n);
    wr(sector_write_pkg::OFF_COUNT, {24'h0, cnt});
    wr(sector_write_pkg::OFF_ADDR_LO, {24'h0, lo});
    wr(sector_write_pkg::OFF_DEVICE, {24'h0, dv});
    wr(sector_write_pkg::OFF_COMMAND, {24'h0, op});
    for (int s = 0; s < n; s++) begin
      poll(3, 1'b1);
      for (int w = 0; w < 256; w++) wr(sector_write_pkg::OFF_DATA, {16'hFFFF, s[7:0], w[7:0]});
    end
    poll(7, 1'b0);
  endtask
  task automatic t_reset();
    rdchk("status", sector_write_pkg::OFF_COMMAND, 32'h50);
    rdchk("count", sector_write_pkg::OFF_COUNT, 32'h01);
    rdchk("device", sector_write_pkg::OFF_DEVICE, 32'hA0);
    rdchk("unmapped", 8'h24, 32'h0);
    check("slverr", {31'h0, serr}, 32'h1);
  endtask
  // Two logical sectors crossing a byte boundary, retry opcode
  task automatic t_lba();
    wr(sector_write_pkg::OFF_ADDR_MI, 32'h0);
    wr(sector_write_pkg::OFF_ADDR_HI, 32'h0);
    cmd(8'h02, 8'hFF, 8'hE3, 8'h31, 2);
    check("last addr", {4'h0, seen_addr}, 32'h03000100);
    check("lba", {31'h0, seen_lba}, 32'h1);
    rdchk("count", sector_write_pkg::OFF_COUNT, 32'h00);
    rdchk("low", sector_write_pkg::OFF_ADDR_LO, 32'h00);
    rdchk("mid", sector_write_pkg::OFF_ADDR_MI, 32'h01);
    rdchk("device", sector_write_pkg::OFF_DEVICE, 32'hE3);
    rdchk("status", sector_write_pkg::OFF_COMMAND, 32'h50);
  endtask
  // Slow media fails the first of 256 sectors
  task automatic t_err();
    bad <= 1'b1;
    slow <= 1'b1;
    wr(sector_write_pkg::OFF_CONTROL, 32'h0);
    cmd(8'h00, 8'h05, 8'hE0, 8'h30, 1);
    check("fail addr", {4'h0, seen_addr}, 32'h00000105);
    rdchk("error", sector_write_pkg::OFF_ERROR, 32'h10);
    rdchk("count", sector_write_pkg::OFF_COUNT, 32'h00);
    rdchk("low", sector_write_pkg::OFF_ADDR_LO, 32'h05);
    rdchk("status", sector_write_pkg::OFF_COMMAND, 32'h51);
  endtask
  // Two geometry sectors rolling onto the next head, then an unknown opcode
  task automatic t_geo();
    bad <= 1'b0;
    slow <= 1'b0;
    cmd(8'h02, 8'h3F, 8'hA2, 8'h30, 2);
    check("geo addr", {4'h0, seen_addr}, 32'h03000101);
    check("geo", {31'h0, seen_lba}, 32'h0);
    rdchk("geo head", sector_write_pkg::OFF_DEVICE, 32'hA3);
    rdchk("geo sector", sector_write_pkg::OFF_ADDR_LO, 32'h01);
    rdchk("error", sector_write_pkg::OFF_ERROR, 32'h00);
    cmd(8'h01, 8'h07, 8'hA2, 8'h20, 0);
    rdchk("abort", sector_write_pkg::OFF_ERROR, 32'h04);
  endtask
  // Fault ends a three-sector write; unrecoverable error with reassign on goes on
  task automatic t_fault();
    fault <= 1'b1;
    cmd(8'h03, 8'h10, 8'hE0, 8'h31, 1);
    rdchk("fault error", sector_write_pkg::OFF_ERROR, 32'h04);
    rdchk("fault left", sector_write_pkg::OFF_COUNT, 32'h03);
    rdchk("fault low", sector_write_pkg::OFF_ADDR_LO, 32'h10);
    rdchk("fault status", sector_write_pkg::OFF_COMMAND, 32'h71);
    fault <= 1'b0;
    bad <= 1'b1;
    wr(sector_write_pkg::OFF_CONTROL, 32'h1);
    cmd(8'h01, 8'h20, 8'hE0, 8'h30, 1);
    check("remap addr", {4'h0, seen_addr}, 32'h00000120);
    rdchk("remap error", sector_write_pkg::OFF_ERROR, 32'h00);
    rdchk("remap count", sector_write_pkg::OFF_COUNT, 32'h00);
    rdchk("remap status", sector_write_pkg::OFF_COMMAND, 32'h50);
  endtask
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    t_reset();
    t_lba();
    t_err();
    t_geo();
    t_fault();
    conclude();
  end
endmodule // test_sector_write_command

bind sector_write_command sector_write_command_props u_props (
  .i_clock       (i_clock),
  .i_rst         (i_rst),
  .i_psel        (i_psel),
  .i_penable     (i_penable),
  .i_pwrite      (i_pwrite),
  .i_paddr       (i_paddr),
  .i_pwdata      (i_pwdata),
  .o_pready      (o_pready),
  .o_pslverr     (o_pslverr),
  .o_word_valid  (o_word_valid),
  .o_word_data   (o_word_data),
  .o_commit      (o_commit),
  .o_commit_addr (o_commit_addr),
  .o_commit_lba  (o_commit_lba)
);
